// file: src/dvm_consts.vh
// Purpose: shared constants of the volume, mute and zero-flag control block
// Assumes: included by every design file of the block, by bare name
// Notes: offsets, field positions, reset values and timing counts live here
`ifndef DVM_CONSTS_VH
`define DVM_CONSTS_VH

// ==========================================
// register offsets
`define DVM_ADDR_MAIN 5'h00
`define DVM_ADDR_FILT 5'h01
`define DVM_ADDR_ZPOL 5'h02
`define DVM_ADDR_LVOL 5'h03
`define DVM_ADDR_RVOL 5'h04
`define DVM_ADDR_LAST 5'h04

// ==========================================
// reset values
`define DVM_MAIN_RESET 8'h8B
`define DVM_FILT_RESET 8'h02
`define DVM_ZPOL_RESET 8'h00
`define DVM_VOL_RESET 8'hFF

// ==========================================
// field positions
`define DVM_TRST_BIT 0
`define DVM_PWR_BIT 1
`define DVM_FMT_LSB 2
`define DVM_FMT_MSB 4
`define DVM_AUTO_BIT 7
`define DVM_MUTE_BIT 0
`define DVM_DEEM_LSB 1
`define DVM_DEEM_MSB 2
`define DVM_SPD_LSB 3
`define DVM_SPD_MSB 4
`define DVM_SLOW_BIT 5
`define DVM_AND_BIT 6
`define DVM_ZEN_BIT 7
`define DVM_INV_BIT 2

// ==========================================
// control frame layout
`define DVM_FRAME_BITS 5'd16
`define DVM_FRAME_HDR 3'b011

// ==========================================
// speed codes and timing counts, in frame periods
`define DVM_SPD_NORMAL 2'b00
`define DVM_SPD_DOUBLE 2'b01
`define DVM_SPD_QUAD 2'b10
`define DVM_STEP_NORMAL 5'd4
`define DVM_STEP_DOUBLE 5'd8
`define DVM_STEP_QUAD 5'd16
`define DVM_ZERO_FRAMES 8192
`define DVM_TRST_TAKE 2'd3
`define DVM_TRST_FREE 2'd2

`endif

// file: src/dvm_serial_port.v
// Purpose: write-only three-wire control port receiver
// Assumes: select, clock and data are already synchronised and filtered
// Notes: one write pulse per complete, well-formed frame to a mapped address while enable_in is high
`timescale 1ns/100ps
`include "dvm_consts.vh"

module dvm_serial_port (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // gating
    input wire enable_in,
    // filtered link levels
    input wire select_n_in,
    input wire control_clock_in,
    input wire control_data_in,
    // register write strobe
    output reg wr_out,
    output reg [4:0] addr_out,
    output reg [7:0] data_out
);

reg sclk_q;
reg sel_q;
reg [15:0] shift;
reg [4:0] count;
wire sclk_rise = control_clock_in & ~sclk_q;
wire sel_rise = select_n_in & ~sel_q;
wire sel_fall = ~select_n_in & sel_q;
wire frame_ok = (count == `DVM_FRAME_BITS) && (shift[15:13] == `DVM_FRAME_HDR);

always @(posedge clk_in) begin
    if (rst_in) begin
        sclk_q <= 1'b1;
        sel_q <= 1'b1;
        shift <= 16'h0000;
        count <= 5'h00;
        wr_out <= 1'b0;
        addr_out <= 5'h00;
        data_out <= 8'h00;
    end else begin
        sclk_q <= control_clock_in;
        sel_q <= select_n_in;
        wr_out <= 1'b0;
        if (sel_fall) begin
            count <= 5'h00;
        end else if (sclk_rise && !select_n_in) begin
            shift <= {shift[14:0], control_data_in};
            if (count != 5'h1F) begin
                count <= count + 5'h01;
            end
        end
        // unused addresses are dropped as a precaution
        if (sel_rise && frame_ok && enable_in && shift[12:8] <= `DVM_ADDR_LAST) begin
            wr_out <= 1'b1;
            addr_out <= shift[12:8];
            data_out <= shift[7:0];
        end
    end
end

endmodule // dvm_serial_port

// file: src/dvm_volume_ramp.v
// Purpose: per-channel soft volume ramp and sample scaling
// Assumes: step_in is a one-cycle tick at the documented step rate
// Notes: gain is level plus its msb over 256, so code FF passes unchanged
`timescale 1ns/100ps
`include "dvm_consts.vh"

module dvm_volume_ramp #(
    parameter WIDTH = 24
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // control
    input wire run_in,
    input wire step_in,
    input wire mute_in,
    input wire [7:0] code_in,
    // sample path
    input wire valid_in,
    input wire [WIDTH-1:0] sample_in,
    output reg valid_out,
    output reg [WIDTH-1:0] sample_out,
    output reg [7:0] level_out
);

wire [7:0] target = mute_in ? 8'h00 : code_in;
wire [8:0] gain = {1'b0, level_out} + {8'h00, level_out[7]};
wire signed [WIDTH+9:0] prod = $signed(sample_in) * $signed({1'b0, gain});

always @(posedge clk_in) begin
    if (rst_in) begin
        level_out <= `DVM_VOL_RESET;
        valid_out <= 1'b0;
        sample_out <= {WIDTH{1'b0}};
    end else begin
        if (step_in && level_out < target) begin
            level_out <= level_out + 8'h01;
        end else if (step_in && level_out > target) begin
            level_out <= level_out - 8'h01;
        end
        valid_out <= valid_in & run_in;
        if (valid_in) begin
            sample_out <= run_in ? prod[WIDTH+7:8] : {WIDTH{1'b0}};
        end
    end
end

endmodule // dvm_volume_ramp

// file: src/dvm_top.v
// Purpose: volume, soft mute, zero detect and power control of a two-channel DAC
// Assumes: sys_clk_in stands for the master clock; samples arrive once per frame
// Notes: link pins are synchronised through three flops and a filter that waits for the last two stages to agree
`timescale 1ns/100ps
`include "dvm_consts.vh"

module dvm_top #(
    parameter WIDTH = 24,
    parameter ZERO_FRAMES = `DVM_ZERO_FRAMES
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // device pins
    input wire powerdown_pin_n_in,
    input wire frame_clock_in,
    // control port pins
    input wire select_n_in,
    input wire control_clock_in,
    input wire control_data_in,
    // clock status from the clock detector
    input wire mclk_present_in,
    input wire [1:0] detected_speed_in,
    // sample input, one pair per frame
    input wire sample_valid_in,
    input wire [WIDTH-1:0] left_sample_in,
    input wire [WIDTH-1:0] right_sample_in,
    // scaled samples toward the modulator
    output wire left_valid_out,
    output wire [WIDTH-1:0] left_out,
    output wire right_valid_out,
    output wire [WIDTH-1:0] right_out,
    // applied volume levels
    output wire [7:0] left_level_out,
    output wire [7:0] right_level_out,
    // zero flags
    output reg zero_flag_left_out,
    output reg zero_flag_right_out,
    // analog path control
    output reg analog_hiz_out,
    output reg common_voltage_out,
    output reg converter_run_out,
    // settings for the rest of the datapath
    output reg [1:0] speed_mode_out,
    output reg [2:0] format_select_out,
    output reg [1:0] deemphasis_select_out,
    output reg slow_rolloff_out
);

// ==========================================
// pin synchronisers
// bit order: select_n, control clock, control data, frame clock, powerdown
localparam [4:0] SYNC_INIT = 5'h03;
wire [4:0] pins = {powerdown_pin_n_in, frame_clock_in, control_data_in,
    control_clock_in, select_n_in};
reg [4:0] sync1;
reg [4:0] sync2;
reg [4:0] sync3;
reg [4:0] pin_lvl;

genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
        always @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                sync1[gi] <= SYNC_INIT[gi];
                sync2[gi] <= SYNC_INIT[gi];
                sync3[gi] <= SYNC_INIT[gi];
                pin_lvl[gi] <= SYNC_INIT[gi];
            end else begin
                sync1[gi] <= pins[gi];
                sync2[gi] <= sync1[gi];
                sync3[gi] <= sync2[gi];
                // a change counts only once the last two stages agree
                if (sync2[gi] == sync3[gi]) begin
                    pin_lvl[gi] <= sync3[gi];
                end
            end
        end
    end
endgenerate

// reset images of the register fields that leave the block directly
localparam [7:0] MAIN_RST = `DVM_MAIN_RESET;
localparam [7:0] FILT_RST = `DVM_FILT_RESET;

wire pdn_ok = pin_lvl[4];
wire frame_lvl = pin_lvl[3];
// pin low or system reset both bring registers back to defaults
wire hard_rst = ~rst_n_in | ~pdn_ok;

reg frame_q;
wire frame_rise = frame_lvl & ~frame_q;

always @(posedge sys_clk_in) begin
    if (hard_rst) begin
        frame_q <= 1'b0;
    end else begin
        frame_q <= frame_lvl;
    end
end

// ==========================================
// control port and registers
wire wr;
wire [4:0] wr_addr;
wire [7:0] wr_data;

dvm_serial_port u_port (
    .clk_in(sys_clk_in),
    .rst_in(hard_rst),
    .enable_in(mclk_present_in),
    .select_n_in(pin_lvl[0]),
    .control_clock_in(pin_lvl[1]),
    .control_data_in(pin_lvl[2]),
    .wr_out(wr),
    .addr_out(wr_addr),
    .data_out(wr_data)
);

reg [7:0] main_control;
reg [7:0] filter_mute_control;
reg [7:0] zero_flag_polarity;
reg [7:0] left_volume;
reg [7:0] right_volume;

// writes land whatever the power and timing reset bits say
always @(posedge sys_clk_in) begin
    if (hard_rst) begin
        main_control <= `DVM_MAIN_RESET;
        filter_mute_control <= `DVM_FILT_RESET;
        zero_flag_polarity <= `DVM_ZPOL_RESET;
        left_volume <= `DVM_VOL_RESET;
        right_volume <= `DVM_VOL_RESET;
    end else if (wr) begin
        case (wr_addr)
            `DVM_ADDR_MAIN: main_control <= wr_data;
            `DVM_ADDR_FILT: filter_mute_control <= wr_data;
            `DVM_ADDR_ZPOL: zero_flag_polarity <= wr_data;
            `DVM_ADDR_LVOL: left_volume <= wr_data;
            `DVM_ADDR_RVOL: right_volume <= wr_data;
            default: main_control <= main_control;
        endcase
    end
end

wire timing_reset_bit = main_control[`DVM_TRST_BIT];
wire power_bit = main_control[`DVM_PWR_BIT];
wire auto_clock_select = main_control[`DVM_AUTO_BIT];
wire soft_mute_bit = filter_mute_control[`DVM_MUTE_BIT];
wire [1:0] speed_select = filter_mute_control[`DVM_SPD_MSB:`DVM_SPD_LSB];
wire zero_and_mode = filter_mute_control[`DVM_AND_BIT];
wire zero_detect_enable = filter_mute_control[`DVM_ZEN_BIT];
wire zero_flag_invert = zero_flag_polarity[`DVM_INV_BIT];

// ==========================================
// speed and step timing
function [4:0] step_len;
    input [1:0] spd;
    begin
        case (spd)
            `DVM_SPD_DOUBLE: step_len = `DVM_STEP_DOUBLE;
            `DVM_SPD_QUAD: step_len = `DVM_STEP_QUAD;
            default: step_len = `DVM_STEP_NORMAL;
        endcase
    end
endfunction

wire [1:0] next_speed = auto_clock_select ? detected_speed_in : speed_select;

// ==========================================
// power-up and internal timing reset
reg powered;
reg int_rst;
reg [1:0] trst_cnt;
reg [4:0] step_cnt;
reg step_tick;
wire running = powered & ~int_rst;

always @(posedge sys_clk_in) begin
    if (hard_rst) begin
        powered <= 1'b0;
        analog_hiz_out <= 1'b1;
        common_voltage_out <= 1'b0;
        converter_run_out <= 1'b0;
        speed_mode_out <= `DVM_SPD_NORMAL;
        format_select_out <= MAIN_RST[`DVM_FMT_MSB:`DVM_FMT_LSB];
        deemphasis_select_out <= FILT_RST[`DVM_DEEM_MSB:`DVM_DEEM_LSB];
        slow_rolloff_out <= 1'b0;
    end else begin
        // no master clock or power bit low: idle without touching registers
        if (!mclk_present_in || !power_bit) begin
            powered <= 1'b0;
        end else if (frame_rise) begin
            powered <= 1'b1;
        end
        analog_hiz_out <= ~powered;
        common_voltage_out <= powered & int_rst;
        converter_run_out <= running;
        speed_mode_out <= next_speed;
        format_select_out <= main_control[`DVM_FMT_MSB:`DVM_FMT_LSB];
        deemphasis_select_out <= filter_mute_control[`DVM_DEEM_MSB:`DVM_DEEM_LSB];
        slow_rolloff_out <= filter_mute_control[`DVM_SLOW_BIT];
    end
end

// counting whole frame edges after the bit change gives the documented windows
always @(posedge sys_clk_in) begin
    if (hard_rst) begin
        int_rst <= 1'b0;
        trst_cnt <= 2'd0;
    end else if (timing_reset_bit != int_rst) begin
        trst_cnt <= 2'd0;
    end else if (frame_rise) begin
        if (trst_cnt == (int_rst ? `DVM_TRST_FREE : `DVM_TRST_TAKE)) begin
            int_rst <= ~int_rst;
            trst_cnt <= 2'd0;
        end else begin
            trst_cnt <= trst_cnt + 2'd1;
        end
    end
end

// one tick per volume step; ramp halts while the converter is idle
always @(posedge sys_clk_in) begin
    if (hard_rst || !running) begin
        step_cnt <= 5'd0;
        step_tick <= 1'b0;
    end else begin
        step_tick <= 1'b0;
        if (frame_rise) begin
            if (step_cnt >= step_len(speed_mode_out) - 5'd1) begin
                step_cnt <= 5'd0;
                step_tick <= 1'b1;
            end else begin
                step_cnt <= step_cnt + 5'd1;
            end
        end
    end
end

// ==========================================
// volume channels
wire [2*WIDTH-1:0] samples_in = {right_sample_in, left_sample_in};
wire [15:0] codes = {right_volume, left_volume};
wire [1:0] ch_valid;
wire [2*WIDTH-1:0] ch_sample;
wire [15:0] ch_level;

generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_vol
        dvm_volume_ramp #(
            .WIDTH(WIDTH)
        ) u_ramp (
            .clk_in(sys_clk_in),
            .rst_in(hard_rst),
            .run_in(running),
            .step_in(step_tick),
            .mute_in(soft_mute_bit),
            .code_in(codes[gi*8 +: 8]),
            .valid_in(sample_valid_in),
            .sample_in(samples_in[gi*WIDTH +: WIDTH]),
            .valid_out(ch_valid[gi]),
            .sample_out(ch_sample[gi*WIDTH +: WIDTH]),
            .level_out(ch_level[gi*8 +: 8])
        );
    end
endgenerate

assign left_valid_out = ch_valid[0];
assign right_valid_out = ch_valid[1];
assign left_out = ch_sample[WIDTH-1:0];
assign right_out = ch_sample[2*WIDTH-1:WIDTH];
assign left_level_out = ch_level[7:0];
assign right_level_out = ch_level[15:8];

// ==========================================
// zero detection
wire [1:0] zero_seen;

generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_zero
        reg [13:0] zcnt;
        always @(posedge sys_clk_in) begin
            if (hard_rst || !running) begin
                zcnt <= 14'h0000;
            end else if (sample_valid_in) begin
                if (samples_in[gi*WIDTH +: WIDTH] != {WIDTH{1'b0}}) begin
                    zcnt <= 14'h0000;
                end else if (zcnt != ZERO_FRAMES[13:0]) begin
                    zcnt <= zcnt + 14'h0001;
                end
            end
        end
        assign zero_seen[gi] = (zcnt == ZERO_FRAMES[13:0]);
    end
endgenerate

wire both_zero = &zero_seen;
wire det_l = zero_and_mode ? both_zero : zero_seen[0];
wire det_r = zero_and_mode ? both_zero : zero_seen[1];

// disable wins over timing reset so a disabled flag never pulses
always @(posedge sys_clk_in) begin
    if (hard_rst || !powered) begin
        zero_flag_left_out <= 1'b0;
        zero_flag_right_out <= 1'b0;
    end else if (!zero_detect_enable) begin
        zero_flag_left_out <= 1'b0;
        zero_flag_right_out <= 1'b0;
    end else if (int_rst) begin
        zero_flag_left_out <= ~zero_flag_invert;
        zero_flag_right_out <= ~zero_flag_invert;
    end else begin
        zero_flag_left_out <= det_l ^ zero_flag_invert;
        zero_flag_right_out <= det_r ^ zero_flag_invert;
    end
end

endmodule // dvm_top

// file: sim/dvm_top_properties.sv
// Purpose: port checker bound to dvm_top
// Assumes: one clock domain, synchronous active-low reset
// Notes: a level jump is legal only while the power-down pin is low
`timescale 1ns/100ps
module dvm_checker #(
    parameter WIDTH = 24
) (
    // clock and reset
    input wire sys_clk_in,
    input wire rst_n_in,
    // inputs
    input wire powerdown_pin_n_in,
    input wire sample_valid_in,
    input wire [WIDTH-1:0] left_sample_in,
    // outputs
    input wire left_valid_out,
    input wire [WIDTH-1:0] left_out,
    input wire [7:0] left_level_out,
    input wire zero_flag_left_out,
    input wire zero_flag_right_out,
    input wire analog_hiz_out,
    input wire common_voltage_out,
    input wire converter_run_out,
    input wire [2:0] format_select_out
);
    // ==========
    // properties
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_level_step: assert property (
        $changed(left_level_out) && powerdown_pin_n_in |->
        left_level_out == $past(left_level_out) + 8'h01 ||
        left_level_out == $past(left_level_out) - 8'h01)
        else $error("level moved by more than one");
    a_step_hold: assert property (
        $changed(left_level_out) |=> $stable(left_level_out) [*8])
        else $error("level stepped too soon");
    a_valid_cause: assert property (
        left_valid_out |-> $past(sample_valid_in))
        else $error("strobe without input sample");
    a_unity_gain: assert property (
        sample_valid_in && converter_run_out && left_level_out == 8'hFF |=>
        !converter_run_out || left_out == $past(left_sample_in))
        else $error("top code altered the sample");
    a_mute_silent: assert property (
        left_valid_out && left_level_out == 8'h00 && $past(left_level_out) == 8'h00
        |-> left_out == {WIDTH{1'b0}})
        else $error("mute level passed signal");
    a_pin_reset: assert property (
        !powerdown_pin_n_in [*8] |->
        analog_hiz_out && left_level_out == 8'hFF && format_select_out == 3'b010)
        else $error("pin low kept old settings");
    a_hiz_flags: assert property (
        analog_hiz_out && $past(analog_hiz_out) |->
        !zero_flag_left_out && !zero_flag_right_out)
        else $error("zero flag high while floating");
    a_common_voltage_idle: assert property (
        common_voltage_out |-> !converter_run_out)
        else $error("converter running at common level");
endmodule // dvm_checker

bind dvm_top dvm_checker #(.WIDTH(WIDTH)) u_chk (
    .sys_clk_in, .rst_n_in, .powerdown_pin_n_in, .sample_valid_in, .left_sample_in,
    .left_valid_out, .left_out, .left_level_out, .zero_flag_left_out,
    .zero_flag_right_out, .analog_hiz_out, .common_voltage_out, .converter_run_out,
    .format_select_out
);

// file: sim/dvm_host_model.sv
// Purpose: host driving the three-wire write-only control port
// Assumes: 200 ns control clock, idle high between frames
// Notes: data toggles while deselected so a stale bit is never reused
`timescale 1ns/100ps
module dvm_host_model (
    // control port pins
    output reg select_n_out,
    output reg control_clock_out,
    output reg control_data_out
);
    initial begin
        select_n_out = 1'b1;
        control_clock_out = 1'b1;
        control_data_out = 1'b0;
    end
    // raw frame, top n bits msb first; short frames serve refusal tests
    task send(input [15:0] word, input integer n);
        integer i;
        begin
            select_n_out = 1'b0;
            for (i = 15; i > 15 - n; i = i - 1) begin
                control_clock_out = 1'b0;
                control_data_out = word[i];
                #100;
                control_clock_out = 1'b1;
                #100;
            end
            #50;
            select_n_out = 1'b1;
            control_data_out = ~control_data_out;
            #200;
        end
    endtask
    task write(input [4:0] addr, input [7:0] data);
        begin
            if (addr <= 5'h04)
                send({2'b01, 1'b1, addr, data}, 16);
        end
    endtask
endmodule // dvm_host_model

// file: sim/dvm_top_tb.sv
// Purpose: self-checking bench for dvm_top
// Assumes: frame of 16 clocks, zero count shortened to 16 frames
// Notes: host model drives the control pins
`timescale 1ns/100ps
`include "dvm_consts.vh"
module dvm_top_tb;
    // ==========
    // wiring
    reg sys_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg powerdown_pin_n_in = 1'b1;
    reg frame_clock_in = 1'b0;
    reg mclk_present_in = 1'b1;
    reg [1:0] detected_speed_in = 2'b01;
    reg sample_valid_in = 1'b0;
    reg [23:0] left_sample_in = 24'h000000;
    reg [23:0] right_sample_in = 24'h000000;
    wire select_n_in, control_clock_in, control_data_in, slow_rolloff_out;
    wire left_valid_out, right_valid_out, zero_flag_left_out, zero_flag_right_out;
    wire [23:0] left_out, right_out;
    wire [7:0] left_level_out, right_level_out;
    wire analog_hiz_out, common_voltage_out, converter_run_out;
    wire [1:0] speed_mode_out, deemphasis_select_out;
    wire [2:0] format_select_out;
    integer err_total = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer fcnt = 0;
    integer nfr = 0;
    integer f0;
    integer s;

    dvm_top #(.WIDTH(24), .ZERO_FRAMES(16)) u_dut (
        .sys_clk_in, .rst_n_in, .powerdown_pin_n_in, .frame_clock_in,
        .select_n_in, .control_clock_in, .control_data_in,
        .mclk_present_in, .detected_speed_in, .sample_valid_in,
        .left_sample_in, .right_sample_in, .left_valid_out, .left_out,
        .right_valid_out, .right_out, .left_level_out, .right_level_out,
        .zero_flag_left_out, .zero_flag_right_out, .analog_hiz_out,
        .common_voltage_out, .converter_run_out, .speed_mode_out,
        .format_select_out, .deemphasis_select_out, .slow_rolloff_out
    );
    dvm_host_model u_host (
        .select_n_out(select_n_in),
        .control_clock_out(control_clock_in),
        .control_data_out(control_data_in)
    );

    always #12.5 sys_clk_in = ~sys_clk_in;
    // frame clock and one sample strobe per frame, well clear of the frame edge
    always @(posedge sys_clk_in) begin
        #2;
        cyc = cyc + 1;
        fcnt = (fcnt + 1) % 16;
        frame_clock_in = fcnt < 8;
        sample_valid_in = fcnt == 12;
        if (fcnt == 0)
            nfr = nfr + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end

    // ==========
    // helpers
    task tick(input integer n);
        begin
            repeat (n) @(posedge sys_clk_in);
            #2;
        end
    endtask
    task chk(input [23:0] got, input [23:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        begin
            u_host.write(a, d);
            tick(1);
        end
    endtask
    task wait_lev(input [7:0] v);
        integer i;
        begin
            for (i = 0; i < 20000 && left_level_out !== v; i = i + 1)
                tick(1);
            chk(left_level_out, v);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    // ==========
    // scenarios
    task t_regs;
        begin
            chk(format_select_out, 3'b010);
            chk(speed_mode_out, detected_speed_in);
            chk(converter_run_out, 1'b1);
            wr(`DVM_ADDR_MAIN, 8'h13);
            wr(`DVM_ADDR_FILT, 8'h36);
            chk(format_select_out, 3'b100);
            chk(speed_mode_out, `DVM_SPD_QUAD);
            // short, bad header, unmapped and clockless frames must all drop
            u_host.send(16'hC200, 15);
            u_host.send(16'hA100, 16);
            u_host.send(16'h6500, 16);
            mclk_present_in = 1'b0;
            wr(`DVM_ADDR_FILT, 8'h00);
            mclk_present_in = 1'b1;
            tick(1);
            chk(deemphasis_select_out, 2'b11);
            chk(slow_rolloff_out, 1'b1);
            powerdown_pin_n_in = 1'b0;
            tick(10);
            chk(slow_rolloff_out, 1'b0);
            chk(analog_hiz_out, 1'b1);
            powerdown_pin_n_in = 1'b1;
            tick(60);
            chk(converter_run_out, 1'b1);
            $display("t_regs done");
        end
    endtask
    task t_volume;
        begin
            wr(`DVM_ADDR_MAIN, 8'h0B);
            left_sample_in = 24'h100000;
            right_sample_in = 24'h100000;
            for (s = 0; s < 3; s = s + 1) begin
                wr(`DVM_ADDR_FILT, {3'b000, s[1:0], 3'b000});
                wr(`DVM_ADDR_LVOL, left_level_out - 8'h03);
                wait_lev(left_level_out - 8'h01);
                f0 = nfr;
                wait_lev(left_level_out - 8'h01);
                chk(nfr - f0, 4 << s);
            end
            wr(`DVM_ADDR_FILT, 8'h00);
            wr(`DVM_ADDR_LVOL, 8'hFE);
            wait_lev(8'hFB);
            wr(`DVM_ADDR_LVOL, 8'hFC);
            wait_lev(8'hFC);
            tick(300);
            chk(left_level_out, 8'hFC);
            chk(right_level_out, 8'hFF);
            chk(left_out, 24'h0FD000);
            chk(right_out, 24'h100000);
            $display("t_volume done");
        end
    endtask
    task t_mute;
        begin
            wr(`DVM_ADDR_FILT, 8'h01);
            wait_lev(8'hFA);
            wr(`DVM_ADDR_FILT, 8'h00);
            wait_lev(8'hFC);
            wr(`DVM_ADDR_FILT, 8'h01);
            f0 = nfr;
            wait_lev(8'h00);
            chk(nfr - f0 >= 1004 && nfr - f0 <= 1009, 1'b1);
            tick(40);
            chk(left_out, 24'h000000);
            wr(`DVM_ADDR_FILT, 8'h00);
            wait_lev(8'h01);
            $display("t_mute done");
        end
    endtask
    task t_zero;
        begin
            wr(`DVM_ADDR_FILT, 8'h80);
            left_sample_in = 24'h000000;
            right_sample_in = 24'h000000;
            tick(16 * 14);
            chk(zero_flag_left_out, 1'b0);
            tick(16 * 4);
            chk(zero_flag_left_out, 1'b1);
            left_sample_in = 24'h000001;
            @(posedge sample_valid_in);
            tick(2);
            chk(zero_flag_left_out, 1'b0);
            chk(zero_flag_right_out, 1'b1);
            wr(`DVM_ADDR_FILT, 8'hC0);
            chk(zero_flag_right_out, 1'b0);
            left_sample_in = 24'h000000;
            tick(16 * 20);
            chk(zero_flag_right_out, 1'b1);
            wr(`DVM_ADDR_ZPOL, 8'h04);
            chk(zero_flag_left_out, 1'b0);
            wr(`DVM_ADDR_ZPOL, 8'h00);
            chk(zero_flag_left_out, 1'b1);
            wr(`DVM_ADDR_FILT, 8'h00);
            chk(zero_flag_right_out, 1'b0);
            wr(`DVM_ADDR_FILT, 8'h80);
            left_sample_in = 24'h000001;
            right_sample_in = 24'h000001;
            wr(`DVM_ADDR_MAIN, 8'h0A);
            tick(32);
            chk(common_voltage_out, 1'b0);
            tick(48);
            chk(common_voltage_out, 1'b1);
            chk(zero_flag_left_out, 1'b1);
            wr(`DVM_ADDR_FILT, 8'h88);
            chk(speed_mode_out, `DVM_SPD_DOUBLE);
            wr(`DVM_ADDR_MAIN, 8'h0B);
            tick(16);
            chk(zero_flag_right_out, 1'b1);
            tick(48);
            chk(zero_flag_right_out, 1'b0);
            chk(converter_run_out, 1'b1);
            $display("t_zero done");
        end
    endtask

    initial begin
        tick(3);
        rst_n_in = 1'b1;
        tick(40);
        t_regs;
        t_volume;
        t_mute;
        t_zero;
        report_and_stop;
    end
endmodule // dvm_top_tb
